/* wide_counter_pkg.sv */
/*
 * Package for the wide counter unit: register offsets, field positions,
 * reset values, prescaler tap positions and the mode and run encodings.
 * Assumes an 8-bit register port with byte addresses as printed.
 */
package wide_counter_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] compare_low_byte_addr = 8'h10;
   localparam logic [7:0] compare_middle_byte_addr = 8'h11;
   localparam logic [7:0] compare_high_bits_addr = 8'h12;
   localparam logic [7:0] gate_period_setting_addr = 8'h13;
   localparam logic [7:0] counter_control_one_addr = 8'h14;

   // ==========================================================
   // Reset values
   localparam logic [7:0] compare_byte_reset = 8'h00;
   localparam logic [1:0] compare_high_reset = 2'h0;
   localparam logic [7:0] gate_period_reset = 8'h00;
   localparam logic [7:0] control_one_reset = 8'h88;

   // ==========================================================
   // Control register one field positions
   localparam int clear_bit_pos = 7;
   localparam int run_hi_pos = 6;
   localparam int run_lo_pos = 5;
   localparam int source_hi_pos = 4;
   localparam int source_lo_pos = 2;
   localparam int mode_hi_pos = 1;
   localparam int mode_lo_pos = 0;

   // Gate period field positions.
   localparam int gate_high_hi_pos = 7;
   localparam int gate_high_lo_pos = 4;
   localparam int gate_low_hi_pos = 3;
   localparam int gate_low_lo_pos = 0;
   localparam logic [4:0] gate_code_base = 5'h10;

   // ==========================================================
   // Encodings
   localparam logic [1:0] run_stop = 2'h0;
   localparam logic [1:0] run_start = 2'h2;
   localparam logic [1:0] mode_timer = 2'h0;
   localparam logic [1:0] mode_reserved = 2'h1;
   localparam logic [1:0] mode_pulse_width = 2'h2;
   localparam logic [1:0] mode_frequency = 2'h3;
   localparam logic [2:0] source_external = 3'h7;

   // ==========================================================
   // Prescaler tap positions: tap n is a one-cycle pulse every 2^n ticks of its divider input (clocks or slow ticks).
   localparam int tap_fc_23 = 23;
   localparam int tap_fc_13 = 13;
   localparam int tap_fc_11 = 11;
   localparam int tap_fc_7 = 7;
   localparam int tap_fc_3 = 3;
   localparam int tap_fs_15 = 15;
   localparam int tap_fs_5 = 5;
   localparam int tap_fs_3 = 3;
   localparam int tap_gate_fc = 12;
   localparam int tap_gate_fs = 4;
   localparam int fast_div_width = 24;
   localparam int slow_div_width = 16;

   // Bus request carried as one group.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage

/* wide_counter_unit.sv */
/*
 * Register and control part of the 18-bit wide counter unit: compare
 * registers, gate period register, control register one, prescalers,
 * the counter itself and the window gate pulse generator.
 * Assumes one clock clk (the fast clock), a one-cycle slow clock tick
 * input, and software that keeps the far-side programming limits.
 */
// Overview of operation
// - Counter is 18 bits, compared to an 18-bit three-byte compare value.
// - Timer mode: on match raise the interrupt, clear counter, keep counting.
// - Low or middle compare write blocks matching until high byte written.
// - High compare byte keeps bits 1..0 only; upper bits read zero.
// - Reads of compare byte addresses return the live counter.
// - Gate high lasts sixteen minus upper code ticks of the gate tick.
// - Gate low lasts sixteen minus lower code ticks of the same tick.
// - Control one holds clear, run, source, mode fields; resets to 0x88.
// - Writing zero to clear bit clears counter and overflow; bit returns to one.
// - Source code selects fast, slow or divided prescaler taps, or the external input edge.
`timescale 1ns/1ps

module wide_counter_unit
   import wide_counter_pkg::*;
#(
   parameter int counter_width = 18
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Clock sources and mode straps
   input wire logic slow_clock_tick,
   input wire logic prescaler_source_bit,
   input wire logic low_speed_operation,
   input wire logic [1:0] gate_tick_select,
   input wire logic external_count_in,
   // Results
   output logic compare_match_irq,
   output logic counter_overflow,
   output logic window_gate,
   output logic [counter_width-1:0] counter_value
);

   // Elaboration check: the three-byte compare layout fixes the width.
   if (counter_width != 18)
   begin : g_width_check
      $error("counter_width must be 18");
   end

   // ==========================================================
   // Register storage
   reg_req_t req;
   logic [7:0] compare_low_byte;
   logic [7:0] compare_middle_byte;
   logic [1:0] compare_high_bits;
   logic [7:0] gate_period_setting;
   logic [7:0] counter_control_one;
   logic match_blocked;
   logic [counter_width-1:0] count;
   logic [counter_width-1:0] compare_value;
   logic [1:0] run_select;
   logic [2:0] count_source_select;
   logic [1:0] operating_mode_select;
   logic running;
   logic clear_request;

   // Bundle the port signals into one request.
   always_comb
   begin
      req.addr = reg_addr;
      req.wdata = reg_wdata;
      req.wr = reg_wr;
      req.rd = reg_rd;
   end

   // Field decode of control register one.
   assign run_select = counter_control_one[run_hi_pos:run_lo_pos];
   assign count_source_select = counter_control_one[source_hi_pos:source_lo_pos];
   assign operating_mode_select = counter_control_one[mode_hi_pos:mode_lo_pos];
   assign compare_value = {compare_high_bits, compare_middle_byte, compare_low_byte};
   assign clear_request = req.wr && (req.addr == counter_control_one_addr)
      && !req.wdata[clear_bit_pos];
   // Reserved run or mode codes keep everything halted.
   assign running = (run_select == run_start)
      && (operating_mode_select != mode_reserved);

   // Compare value bytes.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         compare_low_byte <= compare_byte_reset;
         compare_middle_byte <= compare_byte_reset;
         compare_high_bits <= compare_high_reset;
      end
      else if (req.wr)
      begin
         if (req.addr == compare_low_byte_addr)
            compare_low_byte <= req.wdata;
         if (req.addr == compare_middle_byte_addr)
            compare_middle_byte <= req.wdata;
         if (req.addr == compare_high_bits_addr)
            compare_high_bits <= req.wdata[1:0];
      end
   end

   // Match inhibit between a low or middle write and the high write.
   always_ff @(posedge clk)
   begin
      if (rst)
         match_blocked <= 1'b0;
      else if (req.wr && (req.addr == compare_high_bits_addr))
         match_blocked <= 1'b0;
      else if (req.wr && ((req.addr == compare_low_byte_addr)
               || (req.addr == compare_middle_byte_addr)))
         match_blocked <= 1'b1;
   end

   // Gate period and control register one; the clear bit always reads back one.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         gate_period_setting <= gate_period_reset;
         counter_control_one <= control_one_reset;
      end
      else if (req.wr)
      begin
         if (req.addr == gate_period_setting_addr)
            gate_period_setting <= req.wdata;
         if (req.addr == counter_control_one_addr)
            counter_control_one <= {1'b1, req.wdata[6:0]};
      end
   end

   // ==========================================================
   // Read port: compare addresses show the live counter.
   always_ff @(posedge clk)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (req.rd)
      begin
         unique case (req.addr)
            compare_low_byte_addr: reg_rdata <= count[7:0];
            compare_middle_byte_addr: reg_rdata <= count[15:8];
            compare_high_bits_addr: reg_rdata <= {6'h00, count[17:16]};
            gate_period_setting_addr: reg_rdata <= gate_period_setting;
            counter_control_one_addr: reg_rdata <= counter_control_one;
            default: reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end

   // ==========================================================
   // Prescalers: free-running dividers with single-cycle tap pulses.
   logic [fast_div_width-1:0] fast_div;
   logic [slow_div_width-1:0] slow_div;
   logic [fast_div_width-1:0] fast_tick;
   logic [slow_div_width-1:0] slow_tick;

   always_ff @(posedge clk)
   begin
      if (rst)
         fast_div <= '0;
      else
         fast_div <= fast_div + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         slow_div <= '0;
      else if (slow_clock_tick)
         slow_div <= slow_div + 1'b1;
   end

   // Tap n pulses once every 2^n input ticks, when the low n bits are about to wrap.
   always_comb
   begin
      fast_tick[0] = 1'b1;
      slow_tick[0] = slow_clock_tick;
      for (int i = 1; i < fast_div_width; i++)
         fast_tick[i] = fast_tick[i-1] && fast_div[i-1];
      for (int j = 1; j < slow_div_width; j++)
         slow_tick[j] = slow_tick[j-1] && slow_div[j-1];
   end

   // ==========================================================
   // External count input: two-stage synchroniser and rising edge detect.
   logic ext_meta;
   logic ext_sync;
   logic ext_prev;
   logic ext_edge;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_prev <= 1'b0;
      end
      else
      begin
         ext_meta <= external_count_in;
         ext_sync <= ext_meta;
         ext_prev <= ext_sync;
      end
   end
   assign ext_edge = ext_sync && !ext_prev;

   // Source tick selection; low-speed operation leaves only the clock itself, the slow taps and the external edge.
   logic count_tick;
   logic use_slow_taps;
   assign use_slow_taps = prescaler_source_bit || low_speed_operation;

   always_comb
   begin
      count_tick = 1'b0;
      unique case (count_source_select)
         3'h0: count_tick = 1'b1;
         3'h1: count_tick = low_speed_operation ? 1'b0 : slow_clock_tick;
         3'h2: count_tick = use_slow_taps ? slow_tick[tap_fs_15] : fast_tick[tap_fc_23];
         3'h3: count_tick = use_slow_taps ? slow_tick[tap_fs_5] : fast_tick[tap_fc_13];
         3'h4: count_tick = use_slow_taps ? slow_tick[tap_fs_3] : fast_tick[tap_fc_11];
         3'h5: count_tick = low_speed_operation ? 1'b0 : fast_tick[tap_fc_7];
         3'h6: count_tick = low_speed_operation ? 1'b0 : fast_tick[tap_fc_3];
         3'h7: count_tick = ext_edge;
      endcase
   end

   // ==========================================================
   // Counter, match and overflow.
   logic match_now;
   assign match_now = running && !match_blocked && (count == compare_value)
      && (operating_mode_select == mode_timer);

   always_ff @(posedge clk)
   begin
      if (rst)
         count <= '0;
      else if (clear_request || (run_select == run_stop))
         count <= '0;
      else if (match_now)
         count <= '0;
      else if (running && count_tick)
         count <= count + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         compare_match_irq <= 1'b0;
      else
         compare_match_irq <= match_now;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         counter_overflow <= 1'b0;
      else if (clear_request)
         counter_overflow <= 1'b0;
      else if (running && count_tick && (&count))
         counter_overflow <= 1'b1;
   end

   assign counter_value = count;

   // ==========================================================
   // Window gate pulse: high for 16-upper code ticks, low for 16-lower.
   logic gate_tick;
   logic [4:0] gate_count;
   logic [4:0] gate_limit;

   always_comb
   begin
      gate_tick = 1'b0;
      unique case (gate_tick_select)
         2'h0: gate_tick = use_slow_taps ? slow_tick[tap_gate_fs] : fast_tick[tap_gate_fc];
         2'h1: gate_tick = use_slow_taps ? slow_tick[tap_gate_fs+1] : fast_tick[tap_gate_fc+1];
         2'h2: gate_tick = use_slow_taps ? slow_tick[tap_gate_fs+2] : fast_tick[tap_gate_fc+2];
         2'h3: gate_tick = 1'b0;
      endcase
   end

   assign gate_limit = window_gate
      ? gate_code_base - {1'b0, gate_period_setting[gate_high_hi_pos:gate_high_lo_pos]}
      : gate_code_base - {1'b0, gate_period_setting[gate_low_hi_pos:gate_low_lo_pos]};

   always_ff @(posedge clk)
   begin
      if (rst || !running)
      begin
         gate_count <= 5'h00;
         window_gate <= 1'b0;
      end
      else if (gate_tick)
      begin
         if (gate_count + 5'h01 >= gate_limit)
         begin
            gate_count <= 5'h00;
            window_gate <= !window_gate;
         end
         else
            gate_count <= gate_count + 5'h01;
      end
   end

endmodule // wide_counter_unit

/* wide_counter_unit_monitor.sv */
/* Checker for the wide counter unit: read timing, match pulse, stop, hold and clear.
   Sees only the unit's ports and is bound to it from the testbench top file. */
`timescale 1ns/1ps
module wide_counter_unit_monitor
   import wide_counter_pkg::*;
#(
   parameter int counter_width = 18
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Results
   input wire logic compare_match_irq,
   input wire logic counter_overflow,
   input wire logic window_gate,
   input wire logic [counter_width-1:0] counter_value
);
   // ==========================================================
   // Shadow of control register one, refreshed on every write to it.
   logic [7:0] ctrl_sh;
   logic stopped;
   logic held;
   logic [1:0] mode_sh;
   logic [7:0] cnt_lo;
   always_ff @(posedge clk)
   begin
      if (rst)
         ctrl_sh <= control_one_reset;
      else if (reg_wr && reg_addr == counter_control_one_addr)
         ctrl_sh <= reg_wdata;
   end
   // Decoded run state and the low counter byte.
   assign stopped = (ctrl_sh[run_hi_pos:run_lo_pos] == run_stop);
   assign held = ctrl_sh[run_lo_pos] || (ctrl_sh[mode_hi_pos:mode_lo_pos] == mode_reserved);
   assign mode_sh = ctrl_sh[mode_hi_pos:mode_lo_pos];
   assign cnt_lo = counter_value[7:0];
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // A write that drops the clear bit low.
   sequence s_clear_wr;
      reg_wr && reg_addr == counter_control_one_addr && !reg_wdata[clear_bit_pos];
   endsequence
   // ==========================================================
   // Assertions.
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   chk_high_bits_zero: assert property ($past(reg_rd) && $past(reg_addr) == compare_high_bits_addr
      |-> reg_rdata[7:2] == 6'h00)
      else $error("high compare read shows upper bits");
   chk_read_live: assert property (reg_rd && reg_addr == compare_low_byte_addr
      |=> reg_rdata == $past(cnt_lo))
      else $error("compare low read is not the live counter");
   chk_irq_single: assert property (compare_match_irq |=> !compare_match_irq)
      else $error("match pulse longer than one cycle");
   chk_irq_clears: assert property (compare_match_irq |-> counter_value == '0)
      else $error("counter not cleared with match pulse");
   chk_irq_timer_only: assert property (compare_match_irq |-> $past(mode_sh) == mode_timer)
      else $error("match pulse outside timer mode");
   chk_stop_zero: assert property (stopped && $past(stopped) |-> counter_value == '0)
      else $error("counter not zero while stopped");
   chk_gate_stopped: assert property (stopped && $past(stopped) |-> !window_gate)
      else $error("gate high while stopped");
   chk_hold_still: assert property (held && $past(held) && !$past(reg_wr)
      |-> $stable(counter_value))
      else $error("counter moved under a reserved code");
   chk_clear_write: assert property (s_clear_wr |=> counter_value == '0 && !counter_overflow)
      else $error("clear write left counter or overflow");
endmodule // wide_counter_unit_monitor

/* wide_counter_unit_tb.sv */
/* Self-checking testbench for the wide counter unit with random compare and gate values.
   Assumes the package constants and the register port timing of the unit. */
`timescale 1ns/1ps
module wide_counter_unit_tb;
   import wide_counter_pkg::*;
   logic clk, rst, reg_wr, reg_rd, prescaler_source_bit, external_count_in, low_speed_operation;
   logic slow_clock_tick = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [1:0] gate_tick_select;
   logic compare_match_irq, counter_overflow, window_gate;
   logic [17:0] counter_value;
   logic [31:0] seed = 32'h0000_3415;
   int miscompares = 0, samples_checked = 0, n, c, g, k, m, per;
   // ==========================================================
   // Device under test; the run starts in low-speed operation.
   wide_counter_unit #(.counter_width(18)) u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .slow_clock_tick(slow_clock_tick), .prescaler_source_bit(prescaler_source_bit),
      .low_speed_operation(low_speed_operation), .gate_tick_select(gate_tick_select),
      .external_count_in(external_count_in), .compare_match_irq(compare_match_irq),
      .counter_overflow(counter_overflow), .window_gate(window_gate),
      .counter_value(counter_value));
   // Clock of 100 ns period.
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Slow clock tick in every second cycle.
   always @(posedge clk) slow_clock_tick <= ~slow_clock_tick;
   // ==========================================================
   // Helpers: random source, verdict, compare, bus cycles and waits.
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task test_done();
      if (miscompares == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task check_value(input string what, input logic [17:0] exp, input logic [17:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task step();
      @(posedge clk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      check_value(what, {10'h000, exp}, {10'h000, d});
   endtask
   // Counts cycles until the gate (sel 0) or match pulse (sel 1) shows lvl.
   task wait_for(input bit sel, input logic lvl);
      n = 0;
      while ((sel ? compare_match_irq : window_gate) !== lvl)
      begin
         step();
         n++;
         if (n > 6000)
         begin
            miscompares++;
            test_done();
         end
      end
   endtask
   task pulses(input int cnt);
      repeat (cnt)
      begin
         @(posedge clk);
         external_count_in <= 1'b1;
         repeat (2) @(posedge clk);
         external_count_in <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask
   // ==========================================================
   // Main sequence.
   initial
   begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      low_speed_operation = 1'b1;
      prescaler_source_bit = 1'b0;
      gate_tick_select = 2'h0;
      external_count_in = 1'b0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd_chk("control_one", counter_control_one_addr, control_one_reset);
      rd_chk("gate_period", gate_period_setting_addr, gate_period_reset);
      rd_chk("compare_low", compare_low_byte_addr, 8'h00);
      rd_chk("unmapped", 8'h20, 8'h00);
      // Timer on the fast clock with a random compare value.
      c = 4 + int'(rnd() % 28);
      wr(compare_low_byte_addr, c[7:0]);
      wr(compare_middle_byte_addr, 8'h00);
      wr(compare_high_bits_addr, 8'h00);
      wr(counter_control_one_addr, 8'hc0);
      wait_for(1, 1);
      step();
      wait_for(1, 1);
      check_value("match_period", c[17:0], n[17:0]);
      // Low byte alone: no match until the high byte follows.
      wr(compare_low_byte_addr, 8'h3f);
      g = 0;
      repeat (100)
      begin
         step();
         if (compare_match_irq !== 1'b0) g++;
      end
      check_value("blocked_matches", 18'h00000, g[17:0]);
      wr(counter_control_one_addr, 8'h40);
      wr(compare_high_bits_addr, 8'hfc);
      wait_for(1, 1);
      step();
      wait_for(1, 1);
      check_value("unblocked_period", 18'h0003f, n[17:0]);
      rd_chk("control_after_clear", counter_control_one_addr, 8'hc0);
      // Event counting on the external input, then holds and clear.
      wr(counter_control_one_addr, 8'h88);
      wr(compare_low_byte_addr, 8'hff);
      wr(compare_middle_byte_addr, 8'hff);
      wr(compare_high_bits_addr, 8'h03);
      wr(counter_control_one_addr, 8'hdc);
      c = 1 + int'(rnd() % 40);
      pulses(c);
      rd_chk("count_low", compare_low_byte_addr, c[7:0]);
      rd_chk("count_mid", compare_middle_byte_addr, 8'h00);
      rd_chk("count_high", compare_high_bits_addr, 8'h00);
      wr(counter_control_one_addr, 8'hfc);
      pulses(3);
      rd_chk("held_count", compare_low_byte_addr, c[7:0]);
      wr(counter_control_one_addr, 8'h5c);
      rd_chk("cleared_count", compare_low_byte_addr, 8'h00);
      rd_chk("clear_bit_back", counter_control_one_addr, 8'hdc);
      wr(counter_control_one_addr, 8'h88);
      wr(counter_control_one_addr, 8'hdd);
      pulses(3);
      rd_chk("reserved_mode", compare_low_byte_addr, 8'h00);
      // Slow clock source: one count per tick at full speed, none in low speed.
      m = 1 + int'(rnd() % 60);
      @(posedge clk);
      low_speed_operation <= 1'b0;
      wr(counter_control_one_addr, 8'h88);
      wr(counter_control_one_addr, 8'hc4);
      repeat (2 * m - 2) @(posedge clk);
      wr(counter_control_one_addr, 8'he4);
      rd_chk("slow_count", compare_low_byte_addr, m[7:0]);
      @(posedge clk);
      low_speed_operation <= 1'b1;
      wr(counter_control_one_addr, 8'h44);
      repeat (20) @(posedge clk);
      wr(counter_control_one_addr, 8'he4);
      rd_chk("low_speed_count", compare_low_byte_addr, 8'h00);
      // Gate pulse on slow ticks with random codes and tick choice.
      wr(counter_control_one_addr, 8'h88);
      g = int'(rnd() % 256);
      k = int'(rnd() % 3);
      wr(gate_period_setting_addr, g[7:0]);
      rd_chk("gate_back", gate_period_setting_addr, g[7:0]);
      @(posedge clk);
      prescaler_source_bit <= 1'b1;
      gate_tick_select <= k[1:0];
      per = 1 << (tap_gate_fs + 1 + k);
      wr(counter_control_one_addr, 8'hc0);
      wait_for(0, 1);
      wait_for(0, 0);
      check_value("gate_high", 18'((16 - g[7:4]) * per), n[17:0]);
      wait_for(0, 1);
      check_value("gate_low", 18'((16 - g[3:0]) * per), n[17:0]);
      test_done();
   end
endmodule // wide_counter_unit_tb

bind wide_counter_unit wide_counter_unit_monitor #(.counter_width(counter_width)) u_monitor (
   .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_match_irq(compare_match_irq),
   .counter_overflow(counter_overflow), .window_gate(window_gate),
   .counter_value(counter_value));
